/* File: core/optcfg_pkg.sv */
// Package with offsets, field positions and timing counts of the option block.
package optcfg_pkg;

    localparam logic [3:0] OPT_ADDR_TWO = 4'hE;
    localparam logic [3:0] OPT_ADDR_ONE = 4'hF;
    localparam logic [15:0] OPT_BASE_ADDR = 16'h0010;

    localparam logic [7:0] OPT_TWO_RESET = 8'h00;
    localparam logic [7:0] OPT_ONE_RESET = 8'h00;

    // Field positions in option register two.
    localparam int OPT2_SERIAL_SRC_BIT = 0;
    localparam int OPT2_OSC_IN_STOP_BIT = 1;
    localparam int OPT2_TIMEBASE_BIT = 3;
    localparam int OPT2_EXT_CLK_EN_BIT = 4;
    localparam int OPT2_SLOW_BIT = 5;
    localparam int OPT2_XTAL_EN_BIT = 6;
    // Field position in option register one.
    localparam int OPT1_LV_MODE_BIT = 4;

    localparam int STAB_XTAL_CYCLES = 4096;
    localparam int STAB_CLOCK_CYCLES = 16;
    localparam int TB_PRESCALE_DIV = 128;

    typedef enum logic [1:0] {
        OPT_FREQ_WIDE,
        OPT_FREQ_XTAL_FAST,
        OPT_FREQ_XTAL_SLOW
    } optcfg_freq_t;

    typedef struct packed {
        logic serial_clock_source_select;
        logic oscillator_on_in_stop;
        logic timebase_prescale_select;
        logic external_clock_enable;
        logic slow_crystal_select;
        logic crystal_enable;
        logic low_voltage_mode_select;
    } optcfg_opts_t;

    typedef struct packed {
        logic osc1_is_clock;
        logic osc2_is_crystal;
        logic ext_osc_on;
    } optcfg_pins_t;

endpackage

/* File: core/optcfg_top.sv */
// Write-once option registers with their clocking option decodes.
//
// Chosen here: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module optcfg_top (
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    input wire logic por_n_in,
    input wire logic [15:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [7:0] avs_writedata_in,
    output logic [7:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic bus_clk_in,
    input wire logic internal_generated_clock_in,
    input wire logic external_generated_clock_in,
    input wire logic clock_select_ext_in,
    input wire logic stop_mode_in,
    output logic serial_clock_out,
    output logic oscillator_output_clock_out,
    output optcfg_pkg::optcfg_opts_t opts_out,
    output optcfg_pkg::optcfg_pins_t pins_out,
    output optcfg_pkg::optcfg_freq_t monitor_range_out,
    output logic [12:0] stab_timeout_out,
    output logic [7:0] timebase_prediv_out,
    output logic [1:0] locked_out
);
    import optcfg_pkg::*;

    logic [7:0] reg_two;
    logic [7:0] reg_one;
    logic [1:0] lock;
    logic sel_two;
    logic sel_one;
    logic [7:0] rdata_d;
    logic [7:0] rdata_q;
    logic wait_d;
    logic wait_q;
    optcfg_opts_t opts_d;
    optcfg_opts_t opts_q;
    optcfg_pins_t pins_d;
    optcfg_pins_t pins_q;
    optcfg_freq_t range_d;
    optcfg_freq_t range_q;
    logic [12:0] stab_d;
    logic [12:0] stab_q;
    logic [7:0] prediv_d;
    logic [7:0] prediv_q;
    logic xclk_d;
    logic xclk_q;
    logic sclk_d;
    logic sclk_q;
    logic [1:0] lock_q;

    function automatic logic addr_hit(input logic [15:0] a,
                                      input logic [3:0] off);
        addr_hit = (a == (OPT_BASE_ADDR | {12'h000, off}));
    endfunction

    assign sel_two = addr_hit(avs_address_in, OPT_ADDR_TWO);
    assign sel_one = addr_hit(avs_address_in, OPT_ADDR_ONE);

    optcfg_wonce #(
        .RESET_VAL(OPT_TWO_RESET),
        .KEEP_MASK(8'h00)
    ) u_two (
        .core_clk_in(core_clk_in),
        .reset_n_in(reset_n_in),
        .por_n_in(por_n_in),
        .wr_in(avs_write_in && sel_two && !wait_q),
        .wdata_in(avs_writedata_in),
        .value_out(reg_two),
        .locked_out(lock[0])
    );

    optcfg_wonce #(
        .RESET_VAL(OPT_ONE_RESET),
        .KEEP_MASK(8'h01 << OPT1_LV_MODE_BIT)
    ) u_one (
        .core_clk_in(core_clk_in),
        .reset_n_in(reset_n_in),
        .por_n_in(por_n_in),
        .wr_in(avs_write_in && sel_one && !wait_q),
        .wdata_in(avs_writedata_in),
        .value_out(reg_one),
        .locked_out(lock[1])
    );

    // Bus: one wait cycle per request, answer on the second edge.
    always_comb
    begin
        wait_d = 1'b1;
        rdata_d = rdata_q;
        if ((avs_read_in || avs_write_in) && wait_q)
        begin
            wait_d = 1'b0;
        end
        if (avs_read_in && wait_q)
        begin
            rdata_d = sel_two ? reg_two : (sel_one ? reg_one : 8'h00);
        end
    end

    always_comb
    begin
        opts_d.serial_clock_source_select = reg_two[OPT2_SERIAL_SRC_BIT];
        opts_d.oscillator_on_in_stop = reg_two[OPT2_OSC_IN_STOP_BIT];
        opts_d.timebase_prescale_select = reg_two[OPT2_TIMEBASE_BIT];
        opts_d.external_clock_enable = reg_two[OPT2_EXT_CLK_EN_BIT];
        opts_d.slow_crystal_select = reg_two[OPT2_SLOW_BIT];
        opts_d.crystal_enable = reg_two[OPT2_XTAL_EN_BIT];
        opts_d.low_voltage_mode_select = reg_one[OPT1_LV_MODE_BIT];
        pins_d.ext_osc_on = opts_d.external_clock_enable;
        pins_d.osc1_is_clock = opts_d.external_clock_enable;
        pins_d.osc2_is_crystal = opts_d.external_clock_enable
                                 && opts_d.crystal_enable;
        stab_d = pins_d.osc2_is_crystal ? 13'(STAB_XTAL_CYCLES)
                                        : 13'(STAB_CLOCK_CYCLES);
        if (!pins_d.osc2_is_crystal)
        begin
            range_d = OPT_FREQ_WIDE;
        end
        else if (opts_d.slow_crystal_select)
        begin
            range_d = OPT_FREQ_XTAL_SLOW;
        end
        else
        begin
            range_d = OPT_FREQ_XTAL_FAST;
        end
        prediv_d = opts_d.timebase_prescale_select
                   ? 8'(TB_PRESCALE_DIV) : 8'h01;
        xclk_d = clock_select_ext_in ? external_generated_clock_in
                                     : internal_generated_clock_in;
        if (stop_mode_in && !opts_d.oscillator_on_in_stop)
        begin
            xclk_d = 1'b0;
        end
        sclk_d = opts_d.serial_clock_source_select ? bus_clk_in : xclk_d;
        if (stop_mode_in && !opts_d.oscillator_on_in_stop)
        begin
            sclk_d = 1'b0;
        end
    end

    always_ff @(posedge core_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            rdata_q <= 8'h00;
            wait_q <= 1'b1;
            opts_q <= '0;
            pins_q <= '0;
            range_q <= OPT_FREQ_WIDE;
            stab_q <= 13'(STAB_CLOCK_CYCLES);
            prediv_q <= 8'h01;
            xclk_q <= 1'b0;
            sclk_q <= 1'b0;
            lock_q <= 2'h0;
        end
        else
        begin
            rdata_q <= rdata_d;
            wait_q <= wait_d;
            opts_q <= opts_d;
            pins_q <= pins_d;
            range_q <= range_d;
            stab_q <= stab_d;
            prediv_q <= prediv_d;
            xclk_q <= xclk_d;
            sclk_q <= sclk_d;
            lock_q <= lock;
        end
    end

    assign avs_readdata_out = rdata_q;
    assign avs_waitrequest_out = wait_q;
    assign opts_out = opts_q;
    assign pins_out = pins_q;
    assign monitor_range_out = range_q;
    assign stab_timeout_out = stab_q;
    assign timebase_prediv_out = prediv_q;
    assign oscillator_output_clock_out = xclk_q;
    assign serial_clock_out = sclk_q;
    assign locked_out = lock_q;

    chk_write_once_two: assert property (@(posedge core_clk_in)
        disable iff (!reset_n_in)
        lock[0] |=> $stable(reg_two) || !lock[0])
        else $error("option register two changed after lock");

    chk_lock_sets: assert property (@(posedge core_clk_in)
        disable iff (!reset_n_in)
        (avs_write_in && sel_two && !wait_q) |=> lock[0])
        else $error("lock of register two not set by write");

    chk_stab_count: assert property (@(posedge core_clk_in)
        disable iff (!reset_n_in)
        pins_d.osc2_is_crystal |=> stab_q == 13'd4096)
        else $error("stabilization timeout wrong");

    chk_xtal_gate: assert property (@(posedge core_clk_in)
        disable iff (!reset_n_in)
        pins_q.osc2_is_crystal |-> pins_q.osc1_is_clock)
        else $error("crystal active without external clock");

    chk_stop_low: assert property (@(posedge core_clk_in)
        disable iff (!reset_n_in)
        (stop_mode_in && !opts_d.oscillator_on_in_stop) |=> !xclk_q && !sclk_q)
        else $error("clock running in stop mode");

    chk_prescale: assert property (@(posedge core_clk_in)
        disable iff (!reset_n_in)
        opts_d.timebase_prescale_select |=> prediv_q == 8'd128)
        else $error("timebase prescaler not 128");

    chk_serial_src: assert property (@(posedge core_clk_in)
        disable iff (!reset_n_in)
        (opts_d.serial_clock_source_select && !stop_mode_in)
            |=> sclk_q == $past(bus_clk_in))
        else $error("serial clock not bus clock");

    chk_read_data: assert property (@(posedge core_clk_in)
        disable iff (!reset_n_in)
        (avs_read_in && wait_q && sel_one) |=> rdata_q == $past(reg_one))
        else $error("read data mismatch");

    chk_slow_range: assert property (@(posedge core_clk_in)
        disable iff (!reset_n_in)
        (pins_d.osc2_is_crystal && opts_d.slow_crystal_select)
            |=> range_q == OPT_FREQ_XTAL_SLOW)
        else $error("slow range not selected");

    chk_write_once_one: assert property (@(posedge core_clk_in)
        disable iff (!reset_n_in)
        lock[1] |=> $stable(reg_one) || !lock[1])
        else $error("option register one changed after lock");

    chk_lock_one: assert property (@(posedge core_clk_in)
        disable iff (!reset_n_in)
        (avs_write_in && sel_one && !wait_q) |=> lock[1])
        else $error("lock of register one not set by write");

    chk_ext_off_pins: assert property (@(posedge core_clk_in)
        disable iff (!reset_n_in)
        !opts_d.external_clock_enable |=> !pins_q.osc1_is_clock
            && !pins_q.osc2_is_crystal && !pins_q.ext_osc_on)
        else $error("oscillator pins taken without external clock");

    chk_square_wave: assert property (@(posedge core_clk_in)
        disable iff (!reset_n_in)
        (opts_d.external_clock_enable && !opts_d.crystal_enable)
            |=> pins_q.osc1_is_clock && !pins_q.osc2_is_crystal)
        else $error("square wave pin setting wrong");

    chk_crystal_pins: assert property (@(posedge core_clk_in)
        disable iff (!reset_n_in)
        (opts_d.external_clock_enable && opts_d.crystal_enable)
            |=> pins_q.osc1_is_clock && pins_q.osc2_is_crystal)
        else $error("crystal pin setting wrong");

    chk_wide_range: assert property (@(posedge core_clk_in)
        disable iff (!reset_n_in)
        !pins_d.osc2_is_crystal |=> range_q == OPT_FREQ_WIDE)
        else $error("wide range not selected");

    chk_fast_range: assert property (@(posedge core_clk_in)
        disable iff (!reset_n_in)
        (pins_d.osc2_is_crystal && !opts_d.slow_crystal_select)
            |=> range_q == OPT_FREQ_XTAL_FAST)
        else $error("fast range not selected");

    chk_short_stab: assert property (@(posedge core_clk_in)
        disable iff (!reset_n_in)
        !pins_d.osc2_is_crystal |=> stab_q == 13'd16)
        else $error("short stabilization timeout wrong");

    chk_prescale_off: assert property (@(posedge core_clk_in)
        disable iff (!reset_n_in)
        !opts_d.timebase_prescale_select |=> prediv_q == 8'd1)
        else $error("timebase prescaler not bypassed");

    chk_osc_external: assert property (@(posedge core_clk_in)
        disable iff (!reset_n_in)
        (clock_select_ext_in && !stop_mode_in)
            |=> xclk_q == $past(external_generated_clock_in))
        else $error("oscillator clock not external clock");

    chk_osc_internal: assert property (@(posedge core_clk_in)
        disable iff (!reset_n_in)
        (!clock_select_ext_in && !stop_mode_in)
            |=> xclk_q == $past(internal_generated_clock_in))
        else $error("oscillator clock not internal clock");

    chk_serial_osc: assert property (@(posedge core_clk_in)
        disable iff (!reset_n_in)
        (!opts_d.serial_clock_source_select && !stop_mode_in)
            |=> sclk_q == xclk_q)
        else $error("serial clock not oscillator clock");
endmodule

/* File: core/optcfg_wonce.sv */
// One byte register that accepts only its first write after each system reset.
`timescale 1ns/1ps
module optcfg_wonce #(
    parameter logic [7:0] RESET_VAL = 8'h00,
    parameter logic [7:0] KEEP_MASK = 8'h00
)(
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    input wire logic por_n_in,
    input wire logic wr_in,
    input wire logic [7:0] wdata_in,
    output logic [7:0] value_out,
    output logic locked_out
);
    logic [7:0] val_q;
    logic [7:0] val_d;
    logic lock_q;
    logic lock_d;
    logic [7:0] keep_q;
    logic [7:0] keep_d;

    always_comb
    begin
        val_d = val_q;
        lock_d = lock_q;
        keep_d = keep_q;
        if (wr_in && !lock_q)
        begin
            val_d = wdata_in;
            keep_d = wdata_in & KEEP_MASK;
            lock_d = 1'b1;
        end
    end

    always_ff @(posedge core_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            val_q <= RESET_VAL;
            lock_q <= 1'b0;
        end
        else
        begin
            val_q <= val_d;
            lock_q <= lock_d;
        end
    end

    // Bits in the keep mask survive system reset; only power-on clears them.
    always_ff @(posedge core_clk_in or negedge por_n_in)
    begin
        if (!por_n_in)
        begin
            keep_q <= 8'h00;
        end
        else
        begin
            keep_q <= keep_d;
        end
    end

    assign value_out = (val_q & ~KEEP_MASK) | keep_q;
    assign locked_out = lock_q;
endmodule

/* File: dv/tb_optcfg_top.sv */
// Self-checking bench for the write-once option registers.
`timescale 1ns/1ps
module tb_optcfg_top;
    import optcfg_pkg::*;
    localparam logic [15:0] A2 = 16'h001E;
    localparam logic [15:0] A1 = 16'h001F;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic por_n = 1'b0;
    logic [15:0] adr = 16'h0000;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [7:0] wd = 8'h00;
    logic bclk = 1'b0;
    logic internal_generated_clock = 1'b0;
    logic external_generated_clock = 1'b0;
    logic sel = 1'b0;
    logic stop = 1'b0;
    logic [7:0] rdata;
    logic waitreq;
    logic ser;
    logic osc;
    optcfg_opts_t opts;
    optcfg_pins_t pins;
    optcfg_freq_t rng;
    logic [12:0] stab;
    logic [7:0] prediv;
    logic [1:0] locked;
    logic [7:0] expq[$];
    logic [7:0] v;
    logic [1:0] er;
    int n_fail = 0;
    int checked = 0;
    int cyc = 0;
    int seed;

    always #4 clk = ~clk;

    optcfg_top dut_u (.core_clk_in(clk), .reset_n_in(rst_n),
        .por_n_in(por_n), .avs_address_in(adr), .avs_read_in(rd),
        .avs_write_in(wr), .avs_writedata_in(wd),
        .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
        .bus_clk_in(bclk), .internal_generated_clock_in(internal_generated_clock),
        .external_generated_clock_in(external_generated_clock), .clock_select_ext_in(sel),
        .stop_mode_in(stop), .serial_clock_out(ser),
        .oscillator_output_clock_out(osc), .opts_out(opts),
        .pins_out(pins), .monitor_range_out(rng),
        .stab_timeout_out(stab), .timebase_prediv_out(prediv),
        .locked_out(locked));

    task automatic chk(input string nm, input logic [15:0] seen,
        input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Request is held until waitrequest is sampled low.
    task automatic bus(input logic w, input logic [15:0] a,
        input logic [7:0] d);
        @(posedge clk);
        adr <= a;
        wr <= w;
        rd <= ~w;
        wd <= d;
        do @(posedge clk); while (waitreq !== 1'b0);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    task automatic rd_exp(input logic [15:0] a, input logic [7:0] e);
        expq.push_back(e);
        bus(1'b0, a, 8'h00);
    endtask

    task automatic reset(input logic p);
        @(posedge clk);
        rst_n <= 1'b0;
        por_n <= ~p;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        por_n <= 1'b1;
    endtask

    always @(posedge clk)
    begin
        if (rd && waitreq === 1'b0 && expq.size() > 0)
            chk("readdata", {8'h00, rdata}, {8'h00, expq.pop_front()});
    end

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            conclude();
        end
    end

    initial
    begin
        seed = 25551;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        por_n <= 1'b1;
        rd_exp(A2, 8'h00);
        rd_exp(A1, 8'h00);
        chk("stab", {3'h0, stab}, 16'h0010);
        chk("prediv", {8'h00, prediv}, 16'h0001);
        chk("locked", {14'h0, locked}, 16'h0000);
        $display("test reset values done");
        for (int k = 0; k < 4; k++)
        begin
            reset(1'b1);
            v = 8'($random(seed));
            v[4] = k[0];
            v[6] = k[1];
            bus(1'b1, A2, v);
            bus(1'b1, A2, ~v);
            rd_exp(A2, v);
            chk("locked", {14'h0, locked}, 16'h0001);
            bclk <= 1'b0;
            internal_generated_clock <= 1'b1;
            external_generated_clock <= 1'b0;
            sel <= k[0];
            repeat (3) @(posedge clk);
            chk("pins", {13'h0, pins}, {13'h0, v[4], v[4] & v[6], v[4]});
            er = v[6] ? (v[5] ? 2'h2 : 2'h1) : 2'h0;
            if (v[4])
            begin
                chk("range", {14'h0, rng}, {14'h0, er});
                chk("stab", {3'h0, stab}, v[6] ? 16'h1000 : 16'h0010);
            end
            chk("prediv", {8'h00, prediv}, v[3] ? 16'h0080 : 16'h0001);
            chk("opts", {9'h0, opts}, {9'h0, v[0], v[1], v[3], v[4], v[5], v[6], 1'b0});
            chk("osc", {15'h0, osc}, {15'h0, ~k[0]});
            chk("serial", {15'h0, ser}, {15'h0, ~v[0] & ~k[0]});
            sel <= 1'b0;
            bclk <= 1'b1;
            stop <= 1'b1;
            repeat (3) @(posedge clk);
            chk("stop osc", {15'h0, osc}, {15'h0, v[1]});
            chk("stop serial", {15'h0, ser}, {15'h0, v[1]});
            stop <= 1'b0;
            $display("test option pattern %0d done", k);
        end
        bus(1'b1, A1, 8'h13);
        rd_exp(A1, 8'h13);
        rd_exp(A2, v);
        bus(1'b1, 16'h0020, 8'hA5);
        rd_exp(16'h0020, 8'h00);
        reset(1'b0);
        rd_exp(A1, 8'h10);
        rd_exp(A2, 8'h00);
        reset(1'b1);
        rd_exp(A1, 8'h00);
        repeat (2) @(posedge clk);
        $display("test lock, decode and reset kinds done");
        conclude();
    end
endmodule
